// ### design/drtid_cfg.svh
// Purpose: constants of the debug table identification register bank
// Assumes: 12-bit byte address inside one 4KB block, 32-bit words
// Notes: every offset is a byte address, word aligned
// Functional notes
// - bit 4 of device_config is 0 for dedicated debug bus, 1 with memory.
// - reporting flag 1 is deprecated; reporting 0 is always allowed.
// - entry format bits 3:0 read 0x0 or 0x1 only; 0x2 to 0xF never.
// - device_config is a read-only word at offset 0xFC8.
// - device_config_1 at 0xFC4 and device_config_2 at 0xFC0 read all zero.
// - device_type at 0xFCC reads subclass 0x0, class 0x0, upper bits zero.
// - integration_control at 0xF00 reads zero; functional mode only.
// - lock_access at 0xFB0 write-only, lock_status at 0xFB4; never locked.
// - eight peripheral id words; 5 to 7 zero, bits 31:8 of 0 to 4 zero.
// - bit 3 of peripheral id 2 reads 1, standard-body designer code.
// - size field bits 7:4 of peripheral id 4 reads 0x0, one 4KB block.
// - id words carry part number, designer code and revision constants.
// - format 0x0 means 32-bit table entries, 0x1 means 64-bit entries.
`ifndef DRTID_CFG_SVH
`define DRTID_CFG_SVH

`define DRTID_OFS_INTEG_CTRL 12'hF00
`define DRTID_OFS_LOCK_ACCESS 12'hFB0
`define DRTID_OFS_LOCK_STATUS 12'hFB4
`define DRTID_OFS_DEV_CFG_2 12'hFC0
`define DRTID_OFS_DEV_CFG_1 12'hFC4
`define DRTID_OFS_DEV_CFG 12'hFC8
`define DRTID_OFS_DEV_TYPE 12'hFCC
`define DRTID_OFS_PID_4 12'hFD0
`define DRTID_OFS_PID_0 12'hFE0

`define DRTID_SYSTEM_MEMORY_FLAG_BIT 4
`define DRTID_FMT_LSB 0
`define DRTID_FMT_32 4'h0
`define DRTID_FMT_64 4'h1
`define DRTID_TYPE_SUB 4'h0
`define DRTID_TYPE_MAJOR 4'h0
`define DRTID_PID_STD_BIT 3
`define DRTID_PID_SIZE 4'h0
`define DRTID_ZERO_WORD 32'h0000_0000

`endif

// ### design/drtid_pkg.sv
// Purpose: types of the debug table identification register bank
// Assumes: constants live in drtid_cfg.svh
// Notes: one select code per decoded word, except that all eight peripheral id words share one code
package drtid_pkg;
  typedef enum logic [3:0] {
    DRTID_SEL_NONE,
    DRTID_SEL_INTEG_CTRL,
    DRTID_SEL_LOCK_ACCESS,
    DRTID_SEL_LOCK_STATUS,
    DRTID_SEL_DEV_CFG_2,
    DRTID_SEL_DEV_CFG_1,
    DRTID_SEL_DEV_CFG,
    DRTID_SEL_DEV_TYPE,
    DRTID_SEL_PID
  } drtid_sel_t;
endpackage

// ### design/drtid_pid_words.sv
// Purpose: builds the eight peripheral identification words
// Assumes: all fields are constants; size and bit 3 of id 2 are fixed, the rest given by parameters
// Notes: word index n is peripheral id n
`timescale 1ns/10ps
`include "drtid_cfg.svh"
module drtid_pid_words #(
  // identification values below are arbitrary
  parameter logic [11:0] PART_NUMBER = 12'h5A5,
  parameter logic [6:0] DESIGNER_ID = 7'h3C,
  parameter logic [3:0] DESIGNER_CONT = 4'h0,
  parameter logic [3:0] REVISION = 4'h0,
  parameter logic [3:0] CUSTOMER_MOD = 4'h0,
  parameter logic [3:0] MINOR_REV_FIX = 4'h0
) (
  output logic [7:0][31:0] pid_word
);
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_word
      if (gi == 0) begin : g0
        assign pid_word[gi] = {24'h00_0000, PART_NUMBER[7:0]};
      end else if (gi == 1) begin : g1
        assign pid_word[gi] = {24'h00_0000, DESIGNER_ID[3:0], PART_NUMBER[11:8]};
      end else if (gi == 2) begin : g2
        assign pid_word[gi] = {24'h00_0000, REVISION, 1'b1, DESIGNER_ID[6:4]};
      end else if (gi == 3) begin : g3
        assign pid_word[gi] = {24'h00_0000, MINOR_REV_FIX, CUSTOMER_MOD};
      end else if (gi == 4) begin : g4
        assign pid_word[gi] = {24'h00_0000, `DRTID_PID_SIZE, DESIGNER_CONT};
      end else begin : gz
        assign pid_word[gi] = `DRTID_ZERO_WORD;
      end
    end
  endgenerate
endmodule

// ### design/drtid_regs.sv
// Purpose: read-only identification register bank of a debug table block
// Assumes: plain register port, read data in the cycle after the strobe
// Notes: system memory flag and entry format are fixed by parameters
`timescale 1ns/10ps
`include "drtid_cfg.svh"
module drtid_regs #(
  parameter logic SYSTEM_MEMORY_FLAG_PRESENT = 1'b0,
  parameter logic [3:0] ENTRY_FORMAT = 4'h0,
  // identification values below are arbitrary
  parameter logic [11:0] PART_NUMBER = 12'h5A5,
  parameter logic [6:0] DESIGNER_ID = 7'h3C,
  parameter logic [3:0] DESIGNER_CONT = 4'h0,
  parameter logic [3:0] REVISION = 4'h0,
  parameter logic [3:0] CUSTOMER_MOD = 4'h0,
  parameter logic [3:0] MINOR_REV_FIX = 4'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic system_memory_flag,
  output logic [3:0] entry_format,
  output logic entry_is_64
);
  logic [7:0][31:0] pid_word;
  logic [31:0] next_rdata;
  logic [31:0] dev_cfg_word;
  logic [3:0] fmt_legal;
  drtid_pkg::drtid_sel_t rd_sel;

  function automatic drtid_pkg::drtid_sel_t decode(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'b00};
    if (w == `DRTID_OFS_INTEG_CTRL) begin
      decode = drtid_pkg::DRTID_SEL_INTEG_CTRL;
    end else if (w == `DRTID_OFS_LOCK_ACCESS) begin
      decode = drtid_pkg::DRTID_SEL_LOCK_ACCESS;
    end else if (w == `DRTID_OFS_LOCK_STATUS) begin
      decode = drtid_pkg::DRTID_SEL_LOCK_STATUS;
    end else if (w == `DRTID_OFS_DEV_CFG_2) begin
      decode = drtid_pkg::DRTID_SEL_DEV_CFG_2;
    end else if (w == `DRTID_OFS_DEV_CFG_1) begin
      decode = drtid_pkg::DRTID_SEL_DEV_CFG_1;
    end else if (w == `DRTID_OFS_DEV_CFG) begin
      decode = drtid_pkg::DRTID_SEL_DEV_CFG;
    end else if (w == `DRTID_OFS_DEV_TYPE) begin
      decode = drtid_pkg::DRTID_SEL_DEV_TYPE;
    end else if ({w[11:4], 4'h0} == `DRTID_OFS_PID_4 || {w[11:4], 4'h0} == `DRTID_OFS_PID_0) begin
      decode = drtid_pkg::DRTID_SEL_PID;
    end else begin
      decode = drtid_pkg::DRTID_SEL_NONE;
    end
  endfunction

  // maps 0xFD0..0xFDC to ids 4..7 and 0xFE0..0xFEC to ids 0..3
  function automatic logic [2:0] pid_index(input logic [11:0] a);
    pid_index = {a[4], a[3:2]};
  endfunction

  drtid_pid_words #(
    .PART_NUMBER(PART_NUMBER),
    .DESIGNER_ID(DESIGNER_ID),
    .DESIGNER_CONT(DESIGNER_CONT),
    .REVISION(REVISION),
    .CUSTOMER_MOD(CUSTOMER_MOD),
    .MINOR_REV_FIX(MINOR_REV_FIX)
  ) u_pid (
    .pid_word(pid_word)
  );

  assign fmt_legal = (ENTRY_FORMAT == `DRTID_FMT_64) ? `DRTID_FMT_64 : `DRTID_FMT_32;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_memory_flag <= 1'b0;
      entry_format <= `DRTID_FMT_32;
    end else begin
      system_memory_flag <= SYSTEM_MEMORY_FLAG_PRESENT;
      entry_format <= fmt_legal;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_is_64 <= 1'b0;
    end else begin
      entry_is_64 <= (fmt_legal == `DRTID_FMT_64);
    end
  end

  always_comb begin
    dev_cfg_word = `DRTID_ZERO_WORD;
    dev_cfg_word[`DRTID_SYSTEM_MEMORY_FLAG_BIT] = system_memory_flag;
    dev_cfg_word[`DRTID_FMT_LSB +: 4] = entry_format;
  end

  assign rd_sel = decode(addr);

  always_comb begin
    next_rdata = `DRTID_ZERO_WORD;
    if (rd_en) begin
      unique case (rd_sel)
        drtid_pkg::DRTID_SEL_DEV_CFG: next_rdata = dev_cfg_word;
        drtid_pkg::DRTID_SEL_DEV_TYPE: next_rdata = {24'h00_0000, `DRTID_TYPE_SUB,
                                                     `DRTID_TYPE_MAJOR};
        drtid_pkg::DRTID_SEL_PID: next_rdata = pid_word[pid_index(addr)];
        drtid_pkg::DRTID_SEL_DEV_CFG_1,
        drtid_pkg::DRTID_SEL_DEV_CFG_2,
        drtid_pkg::DRTID_SEL_INTEG_CTRL,
        drtid_pkg::DRTID_SEL_LOCK_STATUS,
        drtid_pkg::DRTID_SEL_LOCK_ACCESS,
        drtid_pkg::DRTID_SEL_NONE: next_rdata = `DRTID_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `DRTID_ZERO_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end

  logic unused_write;
  assign unused_write = wr_en ^ (^wdata);
endmodule

// ### verif/drtid_regs_assertions.sv
// Purpose: port checks of the identification bank
// Assumes: read data stands in the cycle after rd_en only
// Notes: bound to every drtid_regs
`timescale 1ns/10ps
`include "drtid_cfg.svh"
module drtid_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic system_memory_flag,
  input wire logic [3:0] entry_format,
  input wire logic entry_is_64
);
  wire logic [11:0] wa = {addr[11:2], 2'h0};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  cfg_word_a: assert property (
    rd_en && wa == `DRTID_OFS_DEV_CFG |=> rdata == {27'h0, system_memory_flag, entry_format})
    else $error("config word wrong");
  fmt_legal_a: assert property (entry_format == 4'h0 || entry_format == 4'h1)
    else $error("reserved format reported");
  fmt_width_a: assert property (entry_is_64 == (entry_format == 4'h1))
    else $error("entry width mismatch");
  zero_cfg_a: assert property (
    rd_en && (wa == `DRTID_OFS_DEV_CFG_1 || wa == `DRTID_OFS_DEV_CFG_2) |=> rdata == 32'h0)
    else $error("config 1 or 2 not zero");
  dev_type_a: assert property (rd_en && wa == `DRTID_OFS_DEV_TYPE |=> rdata == 32'h0)
    else $error("device type not zero");
  integ_zero_a: assert property (rd_en && wa == 12'hF00 |=> rdata == 32'h0)
    else $error("integration control not zero");
  lock_zero_a: assert property (
    rd_en && (wa == 12'hFB0 || wa == 12'hFB4) |=> rdata == 32'h0)
    else $error("lock word not zero");
  pid_high_a: assert property (
    rd_en && (wa[11:4] == 8'hFD || wa[11:4] == 8'hFE) |=> rdata[31:8] == 24'h0)
    else $error("id upper bits not zero");
  pid_std_a: assert property (rd_en && wa == 12'hFE8 |=> rdata[3])
    else $error("standard designer bit clear");
  pid_size_a: assert property (rd_en && wa == 12'hFD0 |=> rdata[7:4] == 4'h0)
    else $error("size field not zero");
  idle_zero_a: assert property (!rd_en |=> rdata == 32'h0)
    else $error("read data without read");
  write_keep_a: assert property (
    wr_en |=> $stable(system_memory_flag) && $stable(entry_format))
    else $error("write changed state");
endmodule
bind drtid_regs drtid_regs_chk i_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .system_memory_flag(system_memory_flag),
  .entry_format(entry_format), .entry_is_64(entry_is_64));

// ### verif/drtid_dbg_model.sv
// Purpose: debugger side of the register port
// Assumes: strobes change right after a rising edge
// Notes: a released address shows its inverse
`timescale 1ns/10ps
module drtid_dbg_model (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [11:0] addr,
  output logic [31:0] wdata,
  output logic wr_en,
  output logic rd_en
);
  initial begin
    addr = 12'h000;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd2(input logic [11:0] a, input logic [11:0] b, output logic [31:0] da,
    output logic [31:0] db);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    addr <= b;
    #1 da = rdata;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~b;
    #1 db = rdata;
  endtask
endmodule

// ### verif/tb_top.sv
// Purpose: self-checking bench of the identification bank
// Assumes: main instance 64-bit format, no system memory; second has flag and reserved format
// Notes: id parameters set to distinct values
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, d0, d1;
  logic wr_en, rd_en, flag, is64;
  logic [3:0] fmt;
  logic [31:0] rdata_alt, d2;
  logic flag_alt, is64_alt;
  logic [3:0] fmt_alt;
  int fail_count = 0;
  int compares = 0;
  logic [11:0] ofs [15] = '{12'hF00, 12'hFB0, 12'hFB4, 12'hFC0, 12'hFC4, 12'hFC8, 12'hFCC,
    12'hFD0, 12'hFD4, 12'hFD8, 12'hFDC, 12'hFE0, 12'hFE4, 12'hFE8, 12'hFEC};
  logic [31:0] exp [15] = '{0, 0, 0, 0, 0, 32'h01, 0, 32'h06, 0, 0, 0, 32'hA5, 32'hC5, 32'h2B,
    32'h43};
  initial forever #2.5 clk = ~clk;
  drtid_regs #(.ENTRY_FORMAT(4'h1), .DESIGNER_CONT(4'h6), .REVISION(4'h2),
    .CUSTOMER_MOD(4'h3), .MINOR_REV_FIX(4'h4)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .system_memory_flag(flag),
    .entry_format(fmt), .entry_is_64(is64));
  drtid_regs #(.SYSTEM_MEMORY_FLAG_PRESENT(1'b1), .ENTRY_FORMAT(4'h7)) i_dut_alt (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata_alt),
    .system_memory_flag(flag_alt), .entry_format(fmt_alt), .entry_is_64(is64_alt));
  drtid_dbg_model i_dbg (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic t_flags;
    chk("flag", 32'h0, {31'h0, flag});
    chk("format", 32'h1, {28'h0, fmt});
    chk("is64", 32'h1, {31'h0, is64});
  endtask
  task automatic t_alt;
    chk("alt flag", 32'h1, {31'h0, flag_alt});
    chk("alt format", 32'h0, {28'h0, fmt_alt});
    chk("alt is64", 32'h0, {31'h0, is64_alt});
    fork
      i_dbg.rd2(12'hFC8, 12'hFE8, d0, d1);
      begin
        repeat (2) @(posedge clk);
        #1 d2 = rdata_alt;
      end
    join
    chk("alt cfg", 32'h10, d2);
    chk("cfg", 32'h01, d0);
    chk("pid2", 32'h2B, d1);
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1 chk("rst rdata", 32'h0, rdata);
    chk("rst format", 32'h0, {28'h0, fmt});
    chk("rst is64", 32'h0, {31'h0, is64});
    chk("rst flag", 32'h0, {31'h0, flag_alt});
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("again format", 32'h1, {28'h0, fmt});
    chk("again flag", 32'h1, {31'h0, flag_alt});
  endtask
  task automatic t_map;
    for (int i = 0; i < 15; i += 2) begin
      i_dbg.rd2(ofs[i], (i < 14) ? ofs[i + 1] : 12'h800, d0, d1);
      chk("word", exp[i], d0);
      chk("next", (i < 14) ? exp[i + 1] : 32'h0, d1);
    end
  endtask
  task automatic t_wr;
    i_dbg.wr(12'hFB0, 32'hC5AC_CE55);
    i_dbg.wr(12'hF00, 32'h0000_0001);
    i_dbg.wr(12'hFC8, 32'hFFFF_FFFF);
    i_dbg.rd2(12'hF00, 12'hFC8, d0, d1);
    chk("integ", 32'h0, d0);
    chk("cfg", 32'h01, d1);
    @(posedge clk);
    #1 chk("idle", 32'h0, rdata);
  endtask
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 t_flags;
    t_alt;
    t_map;
    t_wr;
    t_reset;
    stop_test;
  end
endmodule
